//--- logic/fsrc_map.vh
`ifndef FSRC_MAP_VH
`define FSRC_MAP_VH

// register byte offsets
`define FSRC_OFS_CTRL       6'h00
`define FSRC_OFS_KEY        6'h04
`define FSRC_OFS_ERASE      6'h08
`define FSRC_OFS_WDATA_LO   6'h0c
`define FSRC_OFS_WDATA_HI   6'h10
`define FSRC_OFS_ADDR       6'h14
`define FSRC_OFS_SEG        6'h18
`define FSRC_OFS_STATUS     6'h1c

// field positions and widths
`define FSRC_CTRL_EN_BIT    0
`define FSRC_ERASE_BLK_BIT  0
`define FSRC_ERASE_SEC_BIT  1
`define FSRC_ST_ARMED_BIT   0
`define FSRC_ST_FIRST_BIT   1
`define FSRC_ST_CLKOK_BIT   2
`define FSRC_ST_REFUSE_BIT  3
`define FSRC_ST_EN_BIT      4
`define FSRC_SEG_W          3
`define FSRC_ADDR_W         16

// reset values
`define FSRC_RST_BYTE       8'h00
`define FSRC_RST_ADDR       16'h0000

// unlock key bytes
`define FSRC_KEY_FIRST      8'hfa
`define FSRC_KEY_SECOND     8'hf5

// flash operation codes
`define FSRC_OP_NONE        2'h0
`define FSRC_OP_BLOCK       2'h1
`define FSRC_OP_SECTOR      2'h2
`define FSRC_OP_WORD        2'h3

// erase unit sizes in 16-bit words, as address masks
`define FSRC_BLOCK_WORDS    16'h2000
`define FSRC_SECTOR_WORDS   16'h0200
`define FSRC_BLOCK_MASK     16'he000
`define FSRC_SECTOR_MASK    16'hfe00

`endif

//--- logic/fsrc_unlock.v
`timescale 1ns/1ps
`include "fsrc_map.vh"

module fsrc_unlock
(
    input wire clock,
    input wire rst_n,
    input wire enable,
    input wire key_wr,
    input wire [7:0] key_data,
    input wire consume,
    output reg armed_ff,
    output reg first_ff
);

    reg nxt_armed;
    reg nxt_first;

    always @*
    begin
        nxt_armed = armed_ff;
        nxt_first = first_ff;
        if (!enable)
        begin
            // disabling rewrite throws away any partial or full unlock
            nxt_armed = 1'b0;
            nxt_first = 1'b0;
        end
        else if (consume)
        begin
            nxt_armed = 1'b0;
            nxt_first = 1'b0;
        end
        else if (key_wr)
        begin
            if (first_ff && key_data == `FSRC_KEY_SECOND)
            begin
                nxt_armed = 1'b1;
                nxt_first = 1'b0;
            end
            else if (key_data == `FSRC_KEY_FIRST)
            begin
                nxt_first = 1'b1;
            end
            else
            begin
                nxt_first = 1'b0;
            end
        end
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            armed_ff <= 1'b0;
            first_ff <= 1'b0;
        end
        else
        begin
            armed_ff <= nxt_armed;
            first_ff <= nxt_first;
        end
    end

endmodule

//--- logic/fsrc_top.v
`timescale 1ns/1ps
`include "fsrc_map.vh"

// Operation
// - a block erase clears one whole 8K-word block in one operation.
// - a sector erase clears one 512-word sector in one operation.
// - a word write stores exactly one 16-bit word at the addressed location.
// - once rewrite is enabled the unlock key arms exactly one operation, and each further one needs a new unlock.
// - from the high-speed RC or PLL source any divided frequency is allowed for rewriting.
// - the key is two bytes in order, and any byte after the first, other than the second or a repeat of the first, cancels it.
// - an erase start bit begins the erase, clears itself when done, and the CPU is held until then.
// - the low data byte goes first, and writing the high byte starts the word write.
module fsrc_top
(
    input wire clock,
    input wire rst_n,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata_ff,
    output reg avs_waitrequest_ff,
    input wire sys_clock_source_select,
    output reg pump_enable_ff,
    output reg flash_req_ff,
    output reg [1:0] flash_op_ff,
    output reg [18:0] flash_addr_ff,
    output reg [15:0] flash_wdata_ff,
    input wire flash_done
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_ACK = 4'b0010;
    localparam [3:0] ST_BUSY = 4'b0100;
    localparam [3:0] ST_HOLD = 4'b1000;

    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg enable_ff;
    reg nxt_enable;
    reg [1:0] erase_ff;
    reg [1:0] nxt_erase;
    reg [7:0] wdata_lo_ff;
    reg [7:0] nxt_wdata_lo;
    reg [7:0] wdata_hi_ff;
    reg [7:0] nxt_wdata_hi;
    reg [`FSRC_ADDR_W-1:0] addr_ff;
    reg [`FSRC_ADDR_W-1:0] nxt_addr;
    reg [`FSRC_SEG_W-1:0] seg_ff;
    reg [`FSRC_SEG_W-1:0] nxt_seg;
    reg refused_ff;
    reg nxt_refused;
    reg [31:0] nxt_readdata;
    reg nxt_waitrequest;
    reg nxt_req;
    reg [1:0] nxt_op;
    reg [18:0] nxt_faddr;
    reg [15:0] nxt_fwdata;
    reg key_wr;
    reg consume;
    reg [1:0] start_op;
    reg [`FSRC_ADDR_W-1:0] op_addr;

    wire armed;
    wire first_seen;
    wire clock_ok;
    wire lane0;
    wire lane1;
    wire may_start;

    // clock select comes from the clock generator on this same clock
    assign clock_ok = sys_clock_source_select;
    assign lane0 = avs_byteenable[0];
    assign lane1 = avs_byteenable[1];
    // no frequency check at all: any high-speed divider setting is fine
    assign may_start = enable_ff & armed & clock_ok;

    fsrc_unlock u_unlock
    (
        .clock(clock),
        .rst_n(rst_n),
        .enable(enable_ff),
        .key_wr(key_wr),
        .key_data(avs_writedata[7:0]),
        .consume(consume),
        .armed_ff(armed),
        .first_ff(first_seen)
    );

    always @*
    begin
        nxt_state = state_ff;
        nxt_enable = enable_ff;
        nxt_erase = erase_ff;
        nxt_wdata_lo = wdata_lo_ff;
        nxt_wdata_hi = wdata_hi_ff;
        nxt_addr = addr_ff;
        nxt_seg = seg_ff;
        nxt_refused = refused_ff;
        nxt_readdata = avs_readdata_ff;
        nxt_waitrequest = 1'b1;
        nxt_req = flash_req_ff;
        nxt_op = flash_op_ff;
        nxt_faddr = flash_addr_ff;
        nxt_fwdata = flash_wdata_ff;
        key_wr = 1'b0;
        consume = 1'b0;
        start_op = `FSRC_OP_NONE;
        op_addr = addr_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (avs_read)
                begin
                    nxt_readdata = 32'h0000_0000;
                    case (avs_address & 6'h3c)
                        `FSRC_OFS_CTRL:
                            nxt_readdata[`FSRC_CTRL_EN_BIT] = enable_ff;
                        `FSRC_OFS_ERASE:
                            nxt_readdata[1:0] = erase_ff;
                        `FSRC_OFS_WDATA_LO:
                            nxt_readdata[7:0] = wdata_lo_ff;
                        `FSRC_OFS_WDATA_HI:
                            nxt_readdata[7:0] = wdata_hi_ff;
                        `FSRC_OFS_ADDR:
                            nxt_readdata[15:0] = addr_ff;
                        `FSRC_OFS_SEG:
                            nxt_readdata[`FSRC_SEG_W-1:0] = seg_ff;
                        `FSRC_OFS_STATUS:
                        begin
                            nxt_readdata[`FSRC_ST_ARMED_BIT] = armed;
                            nxt_readdata[`FSRC_ST_FIRST_BIT] = first_seen;
                            nxt_readdata[`FSRC_ST_CLKOK_BIT] = clock_ok;
                            nxt_readdata[`FSRC_ST_REFUSE_BIT] = refused_ff;
                            nxt_readdata[`FSRC_ST_EN_BIT] = enable_ff;
                            // reading status clears the sticky refusal; a read wins over a write, so no new one can land now
                            nxt_refused = 1'b0;
                        end
                        default:
                            nxt_readdata = 32'h0000_0000;
                    endcase
                    nxt_waitrequest = 1'b0;
                    nxt_state = ST_ACK;
                end
                else if (avs_write)
                begin
                    nxt_readdata = 32'h0000_0000;
                    nxt_waitrequest = 1'b0;
                    nxt_state = ST_ACK;
                    case (avs_address & 6'h3c)
                        `FSRC_OFS_CTRL:
                            if (lane0)
                                nxt_enable = avs_writedata[`FSRC_CTRL_EN_BIT];
                        `FSRC_OFS_KEY:
                            if (lane0)
                                key_wr = 1'b1;
                        `FSRC_OFS_ERASE:
                            if (lane0 && (avs_writedata[1:0] != 2'b00))
                            begin
                                // both bits set means block erase
                                if (avs_writedata[`FSRC_ERASE_BLK_BIT])
                                    start_op = `FSRC_OP_BLOCK;
                                else
                                    start_op = `FSRC_OP_SECTOR;
                            end
                        `FSRC_OFS_WDATA_LO:
                            if (lane0)
                                nxt_wdata_lo = avs_writedata[7:0];
                        `FSRC_OFS_WDATA_HI:
                            if (lane0)
                            begin
                                nxt_wdata_hi = avs_writedata[7:0];
                                start_op = `FSRC_OP_WORD;
                            end
                        `FSRC_OFS_ADDR:
                        begin
                            if (lane0)
                                nxt_addr[7:0] = avs_writedata[7:0];
                            if (lane1)
                                nxt_addr[15:8] = avs_writedata[15:8];
                        end
                        `FSRC_OFS_SEG:
                            if (lane0)
                                nxt_seg = avs_writedata[`FSRC_SEG_W-1:0];
                        default:
                            nxt_state = ST_ACK;
                    endcase
                    if (start_op != `FSRC_OP_NONE)
                    begin
                        if (may_start)
                        begin
                            // erase units are aligned down to their own size
                            case (start_op)
                                `FSRC_OP_BLOCK:
                                    op_addr = addr_ff & `FSRC_BLOCK_MASK;
                                `FSRC_OP_SECTOR:
                                    op_addr = addr_ff & `FSRC_SECTOR_MASK;
                                default:
                                    op_addr = addr_ff;
                            endcase
                            consume = 1'b1;
                            nxt_req = 1'b1;
                            nxt_op = start_op;
                            nxt_faddr = {seg_ff, op_addr};
                            nxt_fwdata = {avs_writedata[7:0], wdata_lo_ff};
                            if (start_op != `FSRC_OP_WORD)
                            begin
                                nxt_erase[`FSRC_ERASE_BLK_BIT] = (start_op == `FSRC_OP_BLOCK);
                                nxt_erase[`FSRC_ERASE_SEC_BIT] = (start_op == `FSRC_OP_SECTOR);
                            end
                            // the bus write is held open until flash reports done
                            nxt_waitrequest = 1'b1;
                            nxt_state = ST_BUSY;
                        end
                        else
                        begin
                            nxt_refused = 1'b1;
                        end
                    end
                end
            end
            ST_ACK:
            begin
                nxt_state = ST_IDLE;
            end
            ST_BUSY:
            begin
                if (flash_done)
                begin
                    nxt_req = 1'b0;
                    nxt_op = `FSRC_OP_NONE;
                    nxt_erase = 2'b00;
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                // one spare cycle so the cleared start bit is settled before release
                nxt_waitrequest = 1'b0;
                nxt_state = ST_ACK;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            enable_ff <= 1'b0;
            erase_ff <= 2'b00;
            wdata_lo_ff <= `FSRC_RST_BYTE;
            wdata_hi_ff <= `FSRC_RST_BYTE;
            addr_ff <= `FSRC_RST_ADDR;
            seg_ff <= 3'h0;
            refused_ff <= 1'b0;
            avs_readdata_ff <= 32'h0000_0000;
            avs_waitrequest_ff <= 1'b1;
            pump_enable_ff <= 1'b0;
            flash_req_ff <= 1'b0;
            flash_op_ff <= `FSRC_OP_NONE;
            flash_addr_ff <= 19'h00000;
            flash_wdata_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            enable_ff <= nxt_enable;
            erase_ff <= nxt_erase;
            wdata_lo_ff <= nxt_wdata_lo;
            wdata_hi_ff <= nxt_wdata_hi;
            addr_ff <= nxt_addr;
            seg_ff <= nxt_seg;
            refused_ff <= nxt_refused;
            avs_readdata_ff <= nxt_readdata;
            avs_waitrequest_ff <= nxt_waitrequest;
            pump_enable_ff <= nxt_enable;
            flash_req_ff <= nxt_req;
            flash_op_ff <= nxt_op;
            flash_addr_ff <= nxt_faddr;
            flash_wdata_ff <= nxt_fwdata;
        end
    end

endmodule

//--- bench/fsrc_chk.sv
`timescale 1ns/1ps
module fsrc_chk
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_write,
    input wire logic avs_waitrequest_ff,
    input wire logic sys_clock_source_select,
    input wire logic pump_enable_ff,
    input wire logic flash_req_ff,
    input wire logic [1:0] flash_op_ff,
    input wire logic [18:0] flash_addr_ff,
    input wire logic [15:0] flash_wdata_ff,
    input wire logic flash_done
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence s_start;
        !flash_req_ff ##1 flash_req_ff;
    endsequence
    sequence s_release;
        !flash_req_ff ##1 !avs_waitrequest_ff;
    endsequence
    blk_align_a: assert property (flash_req_ff && flash_op_ff == 2'h1 |-> flash_addr_ff[12:0] == 13'h0000)
        else $error("block erase address not aligned");
    sec_align_a: assert property (flash_req_ff && flash_op_ff == 2'h2 |-> flash_addr_ff[8:0] == 9'h000)
        else $error("sector erase address not aligned");
    op_hold_a: assert property (flash_req_ff && !flash_done |=> flash_req_ff && $stable(flash_op_ff)
        && $stable(flash_addr_ff) && $stable(flash_wdata_ff))
        else $error("operation changed before done");
    busy_wait_a: assert property (flash_req_ff |-> avs_waitrequest_ff)
        else $error("bus answered during operation");
    done_release_a: assert property (flash_req_ff && flash_done |=> s_release)
        else $error("operation not released after done");
    word_start_a: assert property (s_start ##0 flash_op_ff == 2'h3 |-> $past(avs_write && avs_address[5:2] == 4'h4))
        else $error("word write not started by high byte");
    erase_start_a: assert property (s_start ##0 flash_op_ff != 2'h3 |-> $past(avs_write && avs_address[5:2] == 4'h2))
        else $error("erase not started by start bit");
    gate_ok_a: assert property (s_start |-> $past(sys_clock_source_select) && pump_enable_ff)
        else $error("operation started without clock or enable");
endmodule

//--- bench/fsrc_flash_model.sv
`timescale 1ns/1ps
module fsrc_flash_model
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic flash_req,
    input wire logic [1:0] flash_op,
    input wire logic [18:0] flash_addr,
    input wire logic [15:0] flash_wdata,
    input wire logic [7:0] delay,
    output logic flash_done,
    output logic [1:0] last_op,
    output logic [18:0] last_addr,
    output logic [15:0] last_wdata,
    output logic [7:0] op_count
);
    logic [7:0] cnt;
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            flash_done <= 1'b0;
            cnt <= 8'h00;
            op_count <= 8'h00;
            last_op <= 2'h0;
            last_addr <= 19'h00000;
            last_wdata <= 16'h0000;
        end
        else
        begin
            flash_done <= 1'b0;
            if (flash_req && !flash_done)
            begin
                if (cnt == 8'h00)
                begin
                    last_op <= flash_op;
                    last_addr <= flash_addr;
                    last_wdata <= flash_wdata;
                    op_count <= op_count + 8'h01;
                end
                // done pulse after the programmed busy time
                if (cnt == delay)
                begin
                    flash_done <= 1'b1;
                    cnt <= 8'h00;
                end
                else
                    cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "fsrc_map.vh"
module testbench;
    logic clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, sel = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, rd_q, avs_readdata_ff;
    logic [7:0] delay = 8'h03, op_count;
    logic [3:0] be = 4'hf;
    logic avs_waitrequest_ff, pump_enable_ff, flash_req_ff, flash_done;
    logic [1:0] flash_op_ff, last_op;
    logic [18:0] flash_addr_ff, last_addr;
    logic [15:0] flash_wdata_ff, last_wdata;
    integer mismatches = 0, tests_run = 0, i;
    always #25 clock = ~clock;
    fsrc_top u_dut(.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(be),
        .avs_readdata_ff(avs_readdata_ff), .avs_waitrequest_ff(avs_waitrequest_ff),
        .sys_clock_source_select(sel), .pump_enable_ff(pump_enable_ff), .flash_req_ff(flash_req_ff),
        .flash_op_ff(flash_op_ff), .flash_addr_ff(flash_addr_ff), .flash_wdata_ff(flash_wdata_ff),
        .flash_done(flash_done));
    fsrc_flash_model u_flash(.clock(clock), .rst_n(rst_n), .flash_req(flash_req_ff), .flash_op(flash_op_ff),
        .flash_addr(flash_addr_ff), .flash_wdata(flash_wdata_ff), .delay(delay), .flash_done(flash_done),
        .last_op(last_op), .last_addr(last_addr), .last_wdata(last_wdata), .op_count(op_count));
    task complete_run;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    // held until waitrequest low is sampled, then released for one edge; only the watchdog ends a hang
    task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    begin
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge clock);
        while (avs_waitrequest_ff !== 1'b0)
            @(posedge clock);
        rd_q = avs_readdata_ff;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    end
    endtask
    task rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
    begin
        acc(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
    end
    endtask
    task unl;
    begin
        acc(1'b1, `FSRC_OFS_KEY, 32'h000000fa);
        acc(1'b1, `FSRC_OFS_KEY, 32'h000000f5);
    end
    endtask
    initial
    begin
        #(50 * 20000);
        mismatches = mismatches + 1;
        complete_run;
    end
    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rchk("ctrl reset", `FSRC_OFS_CTRL, 32'h0);
        rchk("status reset", `FSRC_OFS_STATUS, 32'h04);
        unl;
        acc(1'b1, `FSRC_OFS_ERASE, 32'h1);
        chk("ops while disabled", 32'h0, op_count);
        rchk("status refused", `FSRC_OFS_STATUS, 32'h0c);
        acc(1'b1, `FSRC_OFS_CTRL, 32'h1);
        chk("pump on", 32'h1, pump_enable_ff);
        acc(1'b1, `FSRC_OFS_KEY, 32'hfa);
        acc(1'b1, `FSRC_OFS_KEY, 32'h00);
        acc(1'b1, `FSRC_OFS_KEY, 32'hf5);
        rchk("status key cancelled", `FSRC_OFS_STATUS, 32'h14);
        acc(1'b1, `FSRC_OFS_KEY, 32'hfa);
        rchk("status first key", `FSRC_OFS_STATUS, 32'h16);
        acc(1'b1, `FSRC_OFS_KEY, 32'hf5);
        rchk("status armed", `FSRC_OFS_STATUS, 32'h15);
        acc(1'b1, `FSRC_OFS_ADDR, 32'h2345);
        acc(1'b1, `FSRC_OFS_SEG, 32'h5);
        for (i = 1; i < 4; i = i + 1)
        begin
            unl;
            acc(1'b1, `FSRC_OFS_ERASE, i);
            chk("erase count", i, op_count);
            chk("erase op", (i == 2) ? 2 : 1, last_op);
            chk("erase addr", {3'h5, 16'h2345 & ((i == 2) ? `FSRC_SECTOR_MASK : `FSRC_BLOCK_MASK)}, last_addr);
            rchk("start bit cleared", `FSRC_OFS_ERASE, 32'h0);
        end
        acc(1'b1, `FSRC_OFS_ERASE, 32'h2);
        chk("no fresh unlock", 32'h3, op_count);
        rchk("status reused key", `FSRC_OFS_STATUS, 32'h1c);
        delay <= 8'h28;
        unl;
        acc(1'b1, `FSRC_OFS_WDATA_LO, 32'h34);
        chk("low byte no start", 32'h3, op_count);
        acc(1'b1, `FSRC_OFS_WDATA_HI, 32'h12);
        chk("word count", 32'h4, op_count);
        chk("word op", 32'h3, last_op);
        chk("word addr", {13'h0, 3'h5, 16'h2345}, last_addr);
        chk("word data", 32'h1234, last_wdata);
        sel <= 1'b0;
        unl;
        acc(1'b1, `FSRC_OFS_WDATA_HI, 32'h56);
        chk("slow clock refused", 32'h4, op_count);
        sel <= 1'b1;
        be <= 4'h1;
        acc(1'b1, `FSRC_OFS_ADDR, 32'h0000ffff);
        be <= 4'hf;
        rchk("addr low lane only", `FSRC_OFS_ADDR, 32'h23ff);
        rchk("unmapped", 6'h20, 32'h0);
        acc(1'b1, `FSRC_OFS_CTRL, 32'h0);
        chk("pump off", 32'h0, pump_enable_ff);
        complete_run;
    end
endmodule
bind fsrc_top fsrc_chk u_chk(.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
    .avs_waitrequest_ff(avs_waitrequest_ff), .sys_clock_source_select(sys_clock_source_select),
    .pump_enable_ff(pump_enable_ff), .flash_req_ff(flash_req_ff), .flash_op_ff(flash_op_ff),
    .flash_addr_ff(flash_addr_ff), .flash_wdata_ff(flash_wdata_ff), .flash_done(flash_done));
